// File: verilog/adc_scan_pkg.sv
// Package: register map, field positions, reset values and divider counts of the scan control
package adc_scan_pkg;
    localparam int          NUM_UNITS       = 3;
    localparam int          ADDR_W          = 3;
    // Register offsets (one byte register per address)
    localparam logic [2:0]  OFF_CTRL0       = 3'h0;
    localparam logic [2:0]  OFF_STAT0       = 3'h3;
    // Control register fields
    localparam int          CTRL_TRIG_EN    = 7;
    localparam int          CTRL_CKS_HI     = 6;
    localparam int          CTRL_CKS_LO     = 5;
    localparam int          CTRL_START      = 4;
    localparam int          CTRL_SCAN_TYPE  = 3;
    localparam logic [2:0]  CTRL_RSVD_VAL   = 3'h7;
    // Status register fields
    localparam int          STAT_END_FLAG   = 7;
    localparam int          STAT_IRQ_EN     = 6;
    localparam int          STAT_MODE_HI    = 5;
    localparam int          STAT_MODE_LO    = 4;
    localparam int          STAT_RSVD       = 3;
    // Reset values
    localparam logic [1:0]  CKS_RST         = 2'h0;
    localparam logic [1:0]  MODE_RST        = 2'h0;
    localparam logic [2:0]  CHSEL_RST       = 3'h0;
    // Mode codes
    localparam logic [1:0]  MODE_SINGLE     = 2'h0;
    localparam logic [1:0]  MODE_SCAN4      = 2'h1;
    // Conversion clock divide ratios per select code
    localparam logic [5:0]  DIV_CONV_CLOCK_SEL_LO        = 6'h20;
    localparam logic [5:0]  DIV_CONV_CLOCK_SEL_HI        = 6'h10;
    localparam logic [5:0]  DIV_CKS2        = 6'h08;
    localparam logic [5:0]  DIV_CKS3        = 6'h01;
    // First analog input of each unit
    localparam logic [4:0]  BASE_CHAN0      = 5'h08;
    localparam logic [4:0]  BASE_CHAN1      = 5'h0C;
    localparam logic [4:0]  BASE_CHAN2      = 5'h10;

    // Request to the analog core: active flag and analog input number
    typedef struct packed {
        logic       active;
        logic [4:0] chan;
    } conv_req_t;
endpackage

// File: verilog/adc_scan_ctrl.sv
// Start, clock, trigger and channel/scan control for three converter units
// Function
// - Decode channel select to fixed analog input
// - Scan type picks single-cycle or continuous
// - Trigger enable gates hardware start sources
// - Clock select sets conversion clock divide
// - Writing start begins conversion
// - Clearing start stops and idles
// - Single and single-cycle auto-clear start
// - Continuous scan wraps while start set
// - Start cleared by write, reset, standby
// - Scan type 0 single-cycle, 1 continuous
// - Scan type ignored in single mode
// - Low three control bits read one
// - Scan starts lowest channel, goes upward
// - Sequence end sets flag, requests interrupt
// - Mode 00 single, 01 four-channel scan
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps

module adc_scan_unit #(
    parameter logic [4:0] BASE_CHAN = 5'h08,
    parameter logic       CODE_HI   = 1'b1
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Register access
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr_ctrl,
    input  wire logic                   i_wr_stat,
    input  wire logic                   i_rd_stat,
    output logic      [7:0]             o_ctrl_rd,
    output logic      [7:0]             o_stat_rd,
    // Triggers, standby and analog core
    input  wire logic                   i_hw_trig,
    input  wire logic                   i_standby,
    input  wire logic                   i_conv_done,
    output adc_scan_pkg::conv_req_t     o_req,
    output logic                        o_tick,
    output logic                        o_irq
);
    typedef enum logic {ST_IDLE, ST_CONV} unit_state_t;

    unit_state_t state_r;
    logic        trig_en_r;
    logic [1:0]  cks_r;
    logic        start_r;
    logic        scan_type_r;
    logic        end_flag_r;
    logic        flag_seen_r;
    logic        irq_en_r;
    logic [1:0]  mode_r;
    logic [2:0]  chsel_r;
    logic [4:0]  chan_r;
    logic [5:0]  div_cnt_r;
    logic        tick_r;
    logic        irq_r;
    logic        scan_mode;
    logic        cont_scan;
    logic [4:0]  last_chan;
    logic [4:0]  first_chan;
    logic        set_start;
    logic        seq_end;
    logic        auto_clr;
    logic [5:0]  div_val;

    // Mode decode; scan type only matters in scan mode
    // mode code decode
    assign scan_mode  = (mode_r == adc_scan_pkg::MODE_SCAN4);
    assign cont_scan  = scan_mode && scan_type_r;
    // channel range from the select code
    assign last_chan  = BASE_CHAN + {3'h0, chsel_r[1:0]};
    assign first_chan = scan_mode ? BASE_CHAN : last_chan;
    // hardware start gated by trigger enable
    assign set_start  = (i_wr_ctrl && i_wdata[adc_scan_pkg::CTRL_START]) ||
                        (i_hw_trig && trig_en_r);
    assign seq_end    = (state_r == ST_CONV) && start_r && i_conv_done && (chan_r == last_chan);
    // one-shot sequences drop start at their end
    assign auto_clr   = seq_end && !cont_scan;

    // Divide ratio for the conversion clock
    // clock select decode
    always_comb begin
        unique case (cks_r)
            2'h0: div_val = adc_scan_pkg::DIV_CONV_CLOCK_SEL_LO;
            2'h1: div_val = adc_scan_pkg::DIV_CONV_CLOCK_SEL_HI;
            2'h2: div_val = adc_scan_pkg::DIV_CKS2;
            2'h3: div_val = adc_scan_pkg::DIV_CKS3;
        endcase
    end

    // Control register fields other than start
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trig_en_r   <= 1'b0;
            cks_r       <= adc_scan_pkg::CKS_RST;
            scan_type_r <= 1'b0;
        end else if (i_wr_ctrl) begin
            trig_en_r   <= i_wdata[adc_scan_pkg::CTRL_TRIG_EN];
            cks_r       <= i_wdata[adc_scan_pkg::CTRL_CKS_HI:adc_scan_pkg::CTRL_CKS_LO];
            scan_type_r <= i_wdata[adc_scan_pkg::CTRL_SCAN_TYPE];
        end
    end

    // Start bit: standby wins, then any set, then any clear
    // start clear sources
    always_ff @(posedge i_clk) begin
        if (i_rst || i_standby) begin
            start_r <= 1'b0;
        end else if (set_start) begin
            start_r <= 1'b1;
        end else if (i_wr_ctrl || auto_clr) begin
            start_r <= 1'b0;
        end
    end

    // Status register fields
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_en_r <= 1'b0;
            mode_r   <= adc_scan_pkg::MODE_RST;
            chsel_r  <= adc_scan_pkg::CHSEL_RST;
        end else if (i_wr_stat) begin
            irq_en_r <= i_wdata[adc_scan_pkg::STAT_IRQ_EN];
            mode_r   <= i_wdata[adc_scan_pkg::STAT_MODE_HI:adc_scan_pkg::STAT_MODE_LO];
            chsel_r  <= i_wdata[2:0];
        end
    end

    // End flag: set at sequence end, cleared by writing 0 after reading 1
    // end flag and interrupt request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            end_flag_r  <= 1'b0;
            flag_seen_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            if (seq_end) begin
                end_flag_r <= 1'b1;
            end else if (i_wr_stat && flag_seen_r && !i_wdata[adc_scan_pkg::STAT_END_FLAG]) begin
                end_flag_r <= 1'b0;
            end
            if (i_rd_stat && end_flag_r) begin
                flag_seen_r <= 1'b1;
            end else if (i_wr_stat) begin
                flag_seen_r <= 1'b0;
            end
            irq_r <= end_flag_r && irq_en_r;
        end
    end

    // Sequencer: lowest channel first, upward, wrap in continuous scan
    // conversion sequencing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            chan_r  <= BASE_CHAN;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_r) begin
                        state_r <= ST_CONV;
                        chan_r  <= first_chan;
                    end
                end
                ST_CONV: begin
                    if (!start_r) begin
                        state_r <= ST_IDLE;
                    end else if (i_conv_done) begin
                        if (chan_r != last_chan) begin
                            chan_r <= chan_r + 5'h01;
                        end else if (cont_scan) begin
                            chan_r <= first_chan;
                        end else if (!set_start) begin
                            state_r <= ST_IDLE;
                        end else begin
                            chan_r <= first_chan;
                        end
                    end
                end
            endcase
        end
    end

    // Conversion clock tick, runs only while converting
    // clock divider
    always_ff @(posedge i_clk) begin
        if (i_rst || state_r != ST_CONV) begin
            div_cnt_r <= 6'h00;
            tick_r    <= 1'b0;
        end else if (div_cnt_r == 6'h00) begin
            div_cnt_r <= div_val - 6'h01;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r - 6'h01;
            tick_r    <= 1'b0;
        end
    end

    // Read views and core outputs
    // reserved bits read one
    assign o_ctrl_rd    = {trig_en_r, cks_r, start_r, scan_type_r, adc_scan_pkg::CTRL_RSVD_VAL};
    assign o_stat_rd    = {end_flag_r, irq_en_r, mode_r, 1'b1, chsel_r};
    assign o_req.active = (state_r == ST_CONV);
    assign o_req.chan   = chan_r;
    assign o_tick       = tick_r;
    assign o_irq        = irq_r;

    property p_trig_gated;
        @(posedge i_clk) disable iff (i_rst)
        (i_hw_trig && !trig_en_r && !start_r && !i_wr_ctrl) |=> !start_r;
    endproperty
    a_trig_gated: assert property (p_trig_gated) else $error("trigger started while disabled");

    property p_trig_sets;
        @(posedge i_clk) disable iff (i_rst)
        (i_hw_trig && trig_en_r && !i_standby) |=> start_r;
    endproperty
    a_trig_sets: assert property (p_trig_sets) else $error("enabled trigger did not set start");

    property p_sw_start;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr_ctrl && i_wdata[adc_scan_pkg::CTRL_START] && !i_standby) |=> start_r ##1 o_req.active;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("start write did not begin conversion");

    property p_stop;
        @(posedge i_clk) disable iff (i_rst)
        (!start_r && !$past(start_r)) |-> !o_req.active;
    endproperty
    a_stop: assert property (p_stop) else $error("conversion ran with start cleared");

    property p_auto_clr;
        @(posedge i_clk) disable iff (i_rst)
        (seq_end && !cont_scan && !set_start) |=> !start_r ##1 !o_req.active;
    endproperty
    a_auto_clr: assert property (p_auto_clr) else $error("one-shot sequence kept start");

    property p_wrap;
        @(posedge i_clk) disable iff (i_rst)
        (seq_end && cont_scan && !i_wr_ctrl && !i_standby) |=> (start_r && chan_r == BASE_CHAN);
    endproperty
    a_wrap: assert property (p_wrap) else $error("continuous scan did not wrap");

    property p_first_chan;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == ST_IDLE && start_r && scan_mode) |=> (chan_r == BASE_CHAN);
    endproperty
    a_first_chan: assert property (p_first_chan) else $error("scan did not start lowest");

    property p_flag_irq;
        @(posedge i_clk) disable iff (i_rst)
        (seq_end && irq_en_r && !i_wr_stat) |=> end_flag_r ##1 o_irq;
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("end flag or request missing");

    property p_div8;
        @(posedge i_clk) disable iff (i_rst)
        (tick_r && cks_r == 2'h2) |=> !tick_r [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 tick too early");

    property p_single_chan;
        @(posedge i_clk) disable iff (i_rst)
        (o_req.active && !scan_mode && $stable(chsel_r)) |-> (chan_r == last_chan);
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("single channel decode wrong");
endmodule

module adc_scan_ctrl (
    // Clock and reset
    input  wire logic                                       i_clk,
    input  wire logic                                       i_rst,
    // Register port
    input  wire logic [adc_scan_pkg::ADDR_W-1:0]            i_addr,
    input  wire logic [7:0]                                 i_wdata,
    input  wire logic                                       i_wr,
    input  wire logic                                       i_rd,
    output logic      [7:0]                                 o_rdata,
    // Start sources and standby
    input  wire logic                                       i_ext_trigger_pin,
    input  wire logic                                       i_multi_timer_unit_trig,
    input  wire logic                                       i_motor_timer_unit_trig,
    input  wire logic                                       i_sw_standby,
    input  wire logic [adc_scan_pkg::NUM_UNITS-1:0]         i_mod_standby,
    // Analog core
    input  wire logic [adc_scan_pkg::NUM_UNITS-1:0]         i_conv_done,
    output adc_scan_pkg::conv_req_t [adc_scan_pkg::NUM_UNITS-1:0] o_req,
    output logic      [adc_scan_pkg::NUM_UNITS-1:0]         o_conv_tick,
    output logic      [adc_scan_pkg::NUM_UNITS-1:0]         o_conv_end_interrupt
);
    localparam logic [4:0] BASES [3] = '{adc_scan_pkg::BASE_CHAN0, adc_scan_pkg::BASE_CHAN1,
                                         adc_scan_pkg::BASE_CHAN2};
    localparam logic       HIS   [3] = '{1'b1, 1'b1, 1'b0};

    logic [7:0] ctrl_rd [adc_scan_pkg::NUM_UNITS];
    logic [7:0] stat_rd [adc_scan_pkg::NUM_UNITS];
    logic       hw_trig;
    logic [7:0] rdata_r;

    // Any of the three hardware sources
    assign hw_trig = i_ext_trigger_pin || i_multi_timer_unit_trig || i_motor_timer_unit_trig;

    // One control unit per converter module
    for (genvar u = 0; u < adc_scan_pkg::NUM_UNITS; u++) begin : g_unit
        adc_scan_unit #(
            .BASE_CHAN (BASES[u]),
            .CODE_HI   (HIS[u])
        ) u_unit (
            .i_clk       (i_clk),
            .i_rst       (i_rst),
            .i_wdata     (i_wdata),
            .i_wr_ctrl   (i_wr && i_addr == adc_scan_pkg::OFF_CTRL0 + 3'(u)),
            .i_wr_stat   (i_wr && i_addr == adc_scan_pkg::OFF_STAT0 + 3'(u)),
            .i_rd_stat   (i_rd && i_addr == adc_scan_pkg::OFF_STAT0 + 3'(u)),
            .o_ctrl_rd   (ctrl_rd[u]),
            .o_stat_rd   (stat_rd[u]),
            .i_hw_trig   (hw_trig),
            .i_standby   (i_sw_standby || i_mod_standby[u]),
            .i_conv_done (i_conv_done[u]),
            .o_req       (o_req[u]),
            .o_tick      (o_conv_tick[u]),
            .o_irq       (o_conv_end_interrupt[u])
        );
    end

    // Read data one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                3'h0, 3'h1, 3'h2: rdata_r <= ctrl_rd[2'(i_addr)];
                3'h3, 3'h4, 3'h5: rdata_r <= stat_rd[2'(i_addr - adc_scan_pkg::OFF_STAT0)];
                default:          rdata_r <= 8'h00;
            endcase
        end
    end
    assign o_rdata = rdata_r;

    property p_rsvd_read;
        @(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr < adc_scan_pkg::OFF_STAT0) |=> (o_rdata[2:0] == 3'h7);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not read as one");
endmodule

// File: tb/adc_core_model.sv
// Behavioural analog core: ends each channel after a set number of conversion ticks
`timescale 1ns/100ps

module adc_core_model (
    // Clock and reset
    input  wire logic                                           i_clk,
    input  wire logic                                           i_rst,
    // Requests and ticks from the control block
    input  wire adc_scan_pkg::conv_req_t [adc_scan_pkg::NUM_UNITS-1:0] i_req,
    input  wire logic [adc_scan_pkg::NUM_UNITS-1:0]             i_tick,
    input  wire logic                                           i_slow,
    // Channel finished pulses
    output logic      [adc_scan_pkg::NUM_UNITS-1:0]             o_conv_done
);
    int unsigned ticks [adc_scan_pkg::NUM_UNITS];

    // Count ticks while a unit is busy; a slow core needs more of them per channel
    always_ff @(posedge i_clk) begin
        for (int u = 0; u < adc_scan_pkg::NUM_UNITS; u++) begin
            o_conv_done[u] <= 1'b0;
            if (i_rst || !i_req[u].active || o_conv_done[u]) begin
                ticks[u] <= 0;
            end else if (i_tick[u]) begin
                ticks[u] <= ticks[u] + 1;
                if (ticks[u] + 1 >= (i_slow ? 5 : 2)) begin
                    o_conv_done[u] <= 1'b1;
                end
            end
        end
    end
endmodule

// File: tb/adc_scan_ctrl_tb.sv
// Self-checking bench for the three-unit converter start, clock and scan control
`timescale 1ns/100ps

module adc_scan_ctrl_tb;
    logic                                   clk, rst, wr, rd, ext, multi_timer_unit, motor_timer_unit, sws, slow;
    logic [2:0]                             addr, mods, done, tick, irq;
    logic [7:0]                             wdata, rdata, rv;
    adc_scan_pkg::conv_req_t [2:0]          req;
    int                                     miscompares = 0;
    int                                     cmp_count = 0;

    // Block under test and its analog core
    adc_scan_ctrl dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_ext_trigger_pin(ext), .i_multi_timer_unit_trig(multi_timer_unit),
        .i_motor_timer_unit_trig(motor_timer_unit), .i_sw_standby(sws), .i_mod_standby(mods),
        .i_conv_done(done), .o_req(req), .o_conv_tick(tick), .o_conv_end_interrupt(irq));
    adc_core_model core (.i_clk(clk), .i_rst(rst), .i_req(req), .i_tick(tick), .i_slow(slow),
        .o_conv_done(done));

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Comparison, verdict and register bus helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reg_wr(input int a, input logic [7:0] d);
        @(posedge clk);
        addr <= 3'(a);
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input int a, output logic [7:0] d);
        @(posedge clk);
        addr <= 3'(a);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // only codes legal for the unit
    function automatic logic [2:0] code(input int u, input int lo);
        return {(u != 2), 2'(lo)};
    endfunction
    function automatic logic [4:0] base(input int u);
        return (u == 0) ? adc_scan_pkg::BASE_CHAN0 :
               (u == 1) ? adc_scan_pkg::BASE_CHAN1 : adc_scan_pkg::BASE_CHAN2;
    endfunction
    // Bounded waits on the request and on finished channels
    task automatic wait_act(input int u, input logic v);
        int n;
        n = 0;
        while (req[u].active !== v && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check("request active", {7'h00, req[u].active}, {7'h00, v});
    endtask
    task automatic expect_chans(input int u, input int cnt, input int wrap);
        int n;
        for (int i = 0; i < cnt; i++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n++;
            end while (done[u] !== 1'b1 && n < 2000);
            check("channel done", {7'h00, done[u]}, 8'h01);
            check("scanned input", {3'h0, req[u].chan}, {3'h0, base(u) + 5'(i % wrap)});
        end
    endtask

    // Reset values, read-only low bits and an unmapped address
    task automatic t_regs;
        for (int u = 0; u < 3; u++) begin
            reg_rd(u, rv);
            check("control reset", rv, 8'h07);
            reg_rd(3 + u, rv);
            check("status reset", rv, 8'h08);
        end
        reg_wr(0, 8'hCF);
        reg_rd(0, rv);
        check("control readback", rv, 8'hCF);
        reg_wr(0, 8'h07);
        reg_rd(6, rv);
        check("unmapped read", rv, 8'h00);
    endtask
    // Single conversions on every legal code; scan type must not matter here
    task automatic t_single;
        for (int u = 0; u < 3; u++) begin
            for (int lo = 0; lo < 4; lo++) begin
                reg_wr(3 + u, {4'h4, 1'b1, code(u, lo)});
                reg_wr(u, {4'h5, lo[0], 3'h7});
                wait_act(u, 1'b1);
                check("single input", {3'h0, req[u].chan}, {3'h0, base(u) + 5'(lo)});
                wait_act(u, 1'b0);
                @(posedge clk);
                #1 check("end interrupt", {7'h00, irq[u]}, 8'h01);
                reg_rd(3 + u, rv);
                check("end flag", rv, {4'hC, 1'b1, code(u, lo)});
                reg_wr(3 + u, {4'h4, 1'b1, code(u, lo)});
                repeat (2) @(posedge clk);
                #1 check("interrupt cleared", {7'h00, irq[u]}, 8'h00);
            end
        end
    endtask
    // Single-cycle and continuous scans, then a software stop
    task automatic t_scan(input int u, input int lo);
        reg_wr(3 + u, {4'h1, 1'b1, code(u, lo)});
        reg_wr(u, 8'h57);
        expect_chans(u, lo + 1, lo + 1);
        wait_act(u, 1'b0);
        reg_rd(3 + u, rv);
        check("scan end flag", rv, {4'h9, 1'b1, code(u, lo)});
        slow <= 1'b1;
        // start already clear before type change
        reg_wr(u, 8'h5F);
        expect_chans(u, 2 * lo + 3, lo + 1);
        check("still running", {7'h00, req[u].active}, 8'h01);
        reg_wr(u, 8'h4F);
        repeat (2) @(posedge clk);
        #1 check("stopped", {7'h00, req[u].active}, 8'h00);
        slow <= 1'b0;
    endtask
    // Hardware starts gated by trigger enable; standby clears the start bit
    task automatic pulse(input int s);
        @(posedge clk);
        ext <= (s == 0);
        multi_timer_unit <= (s == 1);
        motor_timer_unit <= (s == 2);
        @(posedge clk);
        {ext, multi_timer_unit, motor_timer_unit} <= 3'h0;
    endtask
    task automatic t_trig;
        reg_wr(4, {4'h0, 1'b1, code(1, 2)});
        reg_wr(1, 8'h47);
        pulse(0);
        repeat (4) @(posedge clk);
        #1 check("gated trigger", {7'h00, req[1].active}, 8'h00);
        reg_wr(1, 8'hC7);
        slow <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            pulse(s);
            wait_act(1, 1'b1);
            check("trigger input", {3'h0, req[1].chan}, 8'h0E);
            @(posedge clk);
            sws <= (s == 1);
            mods <= (s == 2) ? 3'h2 : 3'h0;
            @(posedge clk);
            sws <= 1'b0;
            mods <= 3'h0;
            wait_act(1, 1'b0);
            reg_rd(1, rv);
            check("start cleared", rv, 8'hC7);
        end
        slow <= 1'b0;
    endtask
    // Tick spacing for each divided clock code
    task automatic t_clock;
        int n;
        logic [7:0] div [3] = '{8'h20, 8'h10, 8'h08};
        reg_wr(5, {4'h0, 1'b1, code(2, 0)});
        slow <= 1'b1;
        // fastest code unused at 50 MHz
        for (int c = 0; c < 3; c++) begin
            reg_wr(2, {1'b0, 2'(c), 5'h17});
            n = 0;
            do begin
                @(posedge clk);
                #1 n++;
            end while (tick[2] !== 1'b1 && n < 100);
            n = 0;
            do begin
                @(posedge clk);
                #1 n++;
            end while (tick[2] !== 1'b1 && n < 100);
            check("tick spacing", 8'(n), div[c]);
            wait_act(2, 1'b0);
        end
        slow <= 1'b0;
    endtask

    // Watchdog against a hung bench
    initial begin
        #1_500_000;
        miscompares++;
        give_verdict();
    end
    // Main sequence
    initial begin
        {rst, wr, rd, ext, multi_timer_unit, motor_timer_unit, sws, slow} = 8'h80;
        addr = 3'h0;
        wdata = 8'h00;
        mods = 3'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_single();
        t_scan(0, 3);
        t_scan(2, 1);
        t_trig();
        t_clock();
        give_verdict();
    end
endmodule
